// [logic/channel_output_divider.sv]
`timescale 1ns/1ps
`include "channel_output_divider_regs.svh"

module channel_output_divider
(
    input  wire logic                                      ref_clk,
    input  wire logic                                      rst,
    input  wire logic                                      clk_en,
    input  wire logic                                      setting_we,
    input  wire channel_output_divider_pkg::divider_setting_s setting_wdata,
    output channel_output_divider_pkg::divider_setting_s   setting_rdata,
    output logic                                           div_clk_out,
    output logic [`RATIO_W-1:0]                            total_ratio
);
    import channel_output_divider_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Stored setting and its next value
    divider_setting_s             setting_reg;
    divider_setting_s             setting_next;

    // Prescale counter and its output phase
    logic [`PRE_CNT_W-1:0]        pre_cnt_reg;
    logic [`PRE_CNT_W-1:0]        pre_cnt_next;
    logic                         pre_out_reg;
    logic                         pre_out_next;

    // Power-of-two counter, advanced once per prescale period
    logic [`POW2_CNT_W-1:0]       pow_cnt_reg;
    logic [`POW2_CNT_W-1:0]       pow_cnt_next;

    // Divided channel clock
    logic                         out_reg;
    logic                         out_next;

    ////////////////////////////////////////////////////////////////////////
    // Decoded setting
    logic [`PRE_CNT_W-1:0]        pre_code;
    logic [`POW2_CODE_W-1:0]      pow_raw;
    logic                         pre_bypass;
    logic [`PRE_CNT_W-1:0]        pre_ratio;
    logic [`PRE_CNT_W-1:0]        pre_last;
    logic [`PRE_CNT_W-1:0]        pre_half;
    logic                         pow_reserved;
    logic [`POW2_CODE_W-1:0]      pow_code;

    // Stage control
    logic                         pre_wrap;
    logic [`POW2_CNT_W-1:0]       pow_tap;
    logic                         pow_bit;

    // Ratio arithmetic
    logic [`RATIO_W-1:0]          pre_ratio_wide;
    logic [`RATIO_W-1:0]          cascade_ratio;

    // Reserved prescale codes need no flag: the map clamps them

    ////////////////////////////////////////////////////////////////////////
    // field split
    assign pre_code = setting_reg.prescale_stage;
    assign pow_raw  = setting_reg.power_of_two_stage;

    assign pre_bypass = (pre_code == `PRESCALE_BYPASS);

    // prescale ratio map
    // Reserved codes act as five, so a bad write cannot stall the counter
    always_comb
    begin
        case (pre_code)
            `PRESCALE_BYPASS:
            begin
                pre_ratio = `PRE_RATIO_ONE;
            end
            `PRESCALE_DIV2:
            begin
                pre_ratio = `PRE_RATIO_TWO;
            end
            `PRESCALE_DIV3:
            begin
                pre_ratio = `PRE_RATIO_THREE;
            end
            `PRESCALE_DIV4:
            begin
                pre_ratio = `PRE_RATIO_FOUR;
            end
            `PRESCALE_DIV5:
            begin
                pre_ratio = `PRE_RATIO_FIVE;
            end
            default:
            begin
                pre_ratio = `PRE_RATIO_FIVE;
            end
        endcase
    end

    // Counter end point and duty split
    assign pre_last = pre_ratio - `PRE_STEP;
    assign pre_half = pre_ratio >> 1;

    // reserved power-of-two codes clamp to the largest legal code
    assign pow_reserved = (pow_raw > `POW2_MAX_CODE);
    assign pow_code     = pow_reserved ? `POW2_MAX_CODE : pow_raw;

    ////////////////////////////////////////////////////////////////////////
    // Register write; writes with clk_en low are dropped
    assign setting_next = setting_we ? setting_wdata : setting_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            setting_reg <= `DIV_SETTING_RESET;
        end
        else if (clk_en)
        begin
            setting_reg <= setting_next;
        end
    end

    // Read-back is the stored word, reserved codes included
    assign setting_rdata = setting_reg;

    ////////////////////////////////////////////////////////////////////////
    // Prescale stage: pre_ratio source cycles per output period.
    // Odd ratios give uneven duty; accepted, downstream only sees edges.
    // No phase restart on a new setting: a count past the new end wraps.
    assign pre_wrap     = (pre_cnt_reg >= pre_last);
    assign pre_cnt_next = pre_wrap ? `PRE_CNT_ZERO : pre_cnt_reg + `PRE_STEP;
    assign pre_out_next = (pre_cnt_reg >= pre_half);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pre_cnt_reg <= `PRE_CNT_ZERO;
        end
        else if (clk_en)
        begin
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pre_out_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            pre_out_reg <= pre_out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-of-two stage: free counter advanced by prescale wraps
    assign pow_cnt_next = pre_wrap ? pow_cnt_reg + `POW2_STEP : pow_cnt_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pow_cnt_reg <= `POW2_CNT_ZERO;
        end
        else if (clk_en)
        begin
            pow_cnt_reg <= pow_cnt_next;
        end
    end

    // one tap per bit; bit k repeats every 2^(k+1) prescale periods
    // Reserved codes never reach the taps
    genvar tap_idx;
    generate
        for (tap_idx = 0; tap_idx < `POW2_CNT_W; tap_idx++)
        begin : g_pow_tap
            assign pow_tap[tap_idx] = (pow_code == `POW2_CODE_W'(tap_idx + 1)) & pow_cnt_reg[tap_idx];
        end
    endgenerate

    // Code zero passes the prescale output straight through
    assign pow_bit = (pow_code == `POW2_CODE_ZERO) ? pre_out_reg : |pow_tap;

    ////////////////////////////////////////////////////////////////////////
    // bypass selects the source-rate toggle; cascade otherwise.
    // Divide by one cannot come from a register at ref_clk; this models it
    // as a full-rate toggle marker, the real path is a mux in the clock tree.
    assign out_next = pre_bypass ? ~out_reg : pow_bit;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            out_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            out_reg <= out_next;
        end
    end

    assign div_clk_out = out_reg;

    ////////////////////////////////////////////////////////////////////////
    // total ratio, up to five times 4096
    // product of the two stage ratios, or one when the prescale is bypassed
    // Largest product five shifted by twelve fits the ratio width
    assign pre_ratio_wide = {{(`RATIO_W - `PRE_CNT_W){1'b0}}, pre_ratio};
    assign cascade_ratio  = pre_ratio_wide << pow_code;
    assign total_ratio    = pre_bypass ? `RATIO_ONE : cascade_ratio;

endmodule

// [logic/channel_output_divider_regs.svh]
`ifndef CHANNEL_OUTPUT_DIVIDER_REGS_SVH
`define CHANNEL_OUTPUT_DIVIDER_REGS_SVH

// Divider setting field
`define DIV_SETTING_W        7
`define DIV_SETTING_RESET    7'h0B
`define PRESCALE_LSB         0
`define PRESCALE_MSB         2
`define POW2_LSB             3
`define POW2_MSB             6

// Prescale codes
`define PRESCALE_BYPASS      3'h0
`define PRESCALE_DIV2        3'h1
`define PRESCALE_DIV3        3'h2
`define PRESCALE_DIV4        3'h3
`define PRESCALE_DIV5        3'h4

// Largest legal power-of-two code
`define POW2_MAX_CODE        4'hC
`define POW2_CNT_W           12
`define PRE_CNT_W            3
`define RATIO_W              15
`define POW2_CODE_W          4

// Stage ratios and counter steps
`define PRE_RATIO_ONE        3'h1
`define PRE_RATIO_TWO        3'h2
`define PRE_RATIO_THREE      3'h3
`define PRE_RATIO_FOUR       3'h4
`define PRE_RATIO_FIVE       3'h5
`define PRE_STEP             3'h1
`define PRE_CNT_ZERO         3'h0
`define POW2_STEP            12'h001
`define POW2_CNT_ZERO        12'h000
`define POW2_CODE_ZERO       4'h0
`define RATIO_ONE            15'h0001

`endif

// [logic/channel_output_divider_pkg.sv]
package channel_output_divider_pkg;

    typedef struct packed {
        logic [3:0] power_of_two_stage;
        logic [2:0] prescale_stage;
    } divider_setting_s;

endpackage

// [bench/channel_output_divider_assertions.sv]
`timescale 1ns/1ps
module channel_output_divider_assertions
import channel_output_divider_pkg::*;
(
    input logic             ref_clk,
    input logic             rst,
    input logic             clk_en,
    input logic             setting_we,
    input logic             div_clk_out,
    input divider_setting_s setting_wdata,
    input divider_setting_s setting_rdata,
    input logic [14:0]      total_ratio
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [2:0] pre = setting_rdata[2:0];
    wire [3:0] pow = setting_rdata[6:3];
    property p_wr; clk_en && setting_we |=> setting_rdata == $past(setting_wdata); endproperty
    a_wr: assert property (p_wr) else $error("store");
    property p_byp; pre == 0 |-> total_ratio == 1; endproperty
    a_byp: assert property (p_byp) else $error("bypass");
    property p_pre; pow == 0 && pre inside {[1:4]} |-> total_ratio == pre + 1; endproperty
    a_pre: assert property (p_pre) else $error("prescale");
    property p_pow; pre == 1 && pow < 13 |-> total_ratio == 15'(2) << pow; endproperty
    a_pow: assert property (p_pow) else $error("power");
    property p_max; total_ratio inside {[1:20480]}; endproperty
    a_max: assert property (p_max) else $error("range");
    // Enable low must freeze the clock and the setting
    property p_frz; !clk_en |=> $stable(div_clk_out) && $stable(setting_rdata); endproperty
    a_frz: assert property (p_frz) else $error("freeze");
    // Bypass toggles from its first cycle, yet still wait 40 settled cycles
    property p_tog; pre == 0 && $past(setting_rdata, 40) == setting_rdata && $changed(div_clk_out) && clk_en
        |=> $changed(div_clk_out); endproperty
    a_tog: assert property (p_tog) else $error("toggle");
endmodule
bind channel_output_divider channel_output_divider_assertions chk (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .clk_en        (clk_en),
    .setting_we    (setting_we),
    .div_clk_out   (div_clk_out),
    .setting_wdata (setting_wdata),
    .setting_rdata (setting_rdata),
    .total_ratio   (total_ratio)
);

// [bench/converter_clock_sink.sv]
`timescale 1ns/1ps
module converter_clock_sink
(
    input  logic ref_clk,
    input  logic clk_in,
    output int   period
);
    // Idle level matches the reset level of the divided clock
    logic clk_last = 1'b0;
    int   cnt = 0;
    always @(posedge ref_clk)
    begin
        clk_last <= clk_in;
        if (clk_in && !clk_last)
        begin
            cnt    <= 1;
            period <= cnt;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

// [bench/test_channel_output_divider.sv]
`timescale 1ns/1ps
module test_channel_output_divider;
    import channel_output_divider_pkg::*;
    logic             ref_clk = 1'b0;
    logic             rst = 1'b1;
    logic             clk_en = 1'b1;
    logic             setting_we = 1'b0;
    divider_setting_s setting_wdata = 7'h00;
    divider_setting_s setting_rdata;
    logic             div_clk_out;
    logic [14:0]      total_ratio;
    logic [6:0]       s;
    logic             held;
    logic [6:0]       exp_q[$];
    int               err_count = 0;
    int               n_tests = 0;
    int               period;
    channel_output_divider DUT (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .clk_en        (clk_en),
        .setting_we    (setting_we),
        .setting_wdata (setting_wdata),
        .setting_rdata (setting_rdata),
        .div_clk_out   (div_clk_out),
        .total_ratio   (total_ratio)
    );
    converter_clock_sink sink (
        .ref_clk (ref_clk),
        .clk_in  (div_clk_out),
        .period  (period)
    );
    // Legal codes only; the host must not program reserved ones
    function automatic int model(logic [6:0] v);
        int pre;
        pre = int'(v[2:0]) + 1;
        if (v[2:0] == 3'h0)
            return 1;
        return pre * (1 << int'(v[6:3]));
    endfunction
    task automatic chk(string n, int x, logic [15:0] y);
        n_tests++;
        if (x !== y)
        begin
            $display("wrong value %s expected %0d seen %0d", n, x, y);
            err_count++;
        end
    endtask
    task automatic wr(logic [6:0] v, int w);
        logic [6:0] e;
        @(posedge ref_clk);
        setting_we    <= 1'b1;
        setting_wdata <= v;
        if (clk_en)
            exp_q.push_back(v);
        @(posedge ref_clk);
        setting_we    <= 1'b0;
        repeat (w + 1) @(negedge ref_clk);
        e = exp_q[$];
        chk("setting", e, setting_rdata);
        chk("ratio", model(e), total_ratio);
        if (w > 0)
            chk("period", (e[2:0] == 3'h0) ? 2 : model(e), period);
    endtask
    task final_report(bit late);
        err_count += late;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #25 ref_clk = ~ref_clk;
    initial #1ms final_report(1);
    initial
    begin
        void'($urandom(36));
        exp_q.push_back(7'h0B);
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (30) @(negedge ref_clk);
        chk("period", 8, period);
        chk("reset", 7'h0B, setting_rdata);
        chk("ratio", 8, total_ratio);
        // ratio four as prescale four, not two times two
        wr(7'h03, 3 * 4 + 40);
        for (int i = 0; i < 48; i++)
        begin
            if (i < 10)
                s = {4'($urandom_range(3)), 3'(i % 5)};
            else
                s = {4'($urandom_range(12)), 3'($urandom_range(4))};
            wr(s, (i < 10) ? 3 * model(s) + 40 : 0);
        end
        // Reset in mid-run restores the default setting
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        exp_q.push_back(7'h0B);
        repeat (30) @(negedge ref_clk);
        chk("reset", 7'h0B, setting_rdata);
        chk("period", 8, period);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        @(negedge ref_clk);
        held = div_clk_out;
        wr(s ^ 7'h7F, 0);
        chk("frozen", held, div_clk_out);
        final_report(0);
    end
endmodule
